// file: hspw_pkg.sv
`default_nettype none
package hspw_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int OC_FILTER_NS = 16000;
  localparam int OL_FILTER_NS = 64000;
  localparam int OC_FILTER_CYC = OC_FILTER_NS / CLK_PERIOD_NS;
  localparam int OL_FILTER_CYC = OL_FILTER_NS / CLK_PERIOD_NS;
  localparam int PERIOD_FAST_NS = 2500000;
  localparam int DUTY_STEPS = 256;
  // One duty step of the 400Hz period, rounded down
  localparam int SLOT_CYC = PERIOD_FAST_NS / (DUTY_STEPS * CLK_PERIOD_NS);
  localparam int FILT_W = 10;
  localparam int SLOT_W = 7;
  // Register indices
  localparam logic [3:0] ADDR_DUTY1 = 4'h0;
  localparam logic [3:0] ADDR_DUTY2 = 4'h1;
  localparam logic [3:0] ADDR_PERIOD = 4'h2;
  localparam logic [3:0] ADDR_SRC_A = 4'h3;
  localparam logic [3:0] ADDR_SRC_B = 4'h4;
  localparam logic [3:0] ADDR_OC_FLAG = 4'h5;
  localparam logic [3:0] ADDR_OL_FLAG = 4'h6;
  localparam logic [3:0] ADDR_SUPPLY = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // Field positions
  localparam int SUP_REC_BIT = 0;
  localparam int SUP_OVDIS_BIT = 1;
  localparam int SUP_UVDIS_BIT = 2;
  localparam int STAT_OV_BIT = 4;
  localparam int STAT_UV_BIT = 5;
  localparam int STAT_FORCED_BIT = 6;
  // Reset values
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [1:0] PERIOD_RST = 2'h0;
  localparam logic [2:0] SUPPLY_RST = 3'h0;
  // Output source codes
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_ON = 3'h1;
  localparam logic [2:0] SRC_TIMER1 = 3'h2;
  localparam logic [2:0] SRC_TIMER2 = 3'h3;
  localparam logic [2:0] SRC_GEN1 = 3'h4;
  localparam logic [2:0] SRC_GEN2 = 3'h5;
  // Device operating mode codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_STOP = 3'h1;
  localparam logic [2:0] MODE_SLEEP = 3'h2;
  localparam logic [2:0] MODE_RESTART = 3'h3;
  localparam logic [2:0] MODE_FAILSAFE = 3'h4;
endpackage
`default_nettype wire

// file: hspw_gen_if.sv
`timescale 1ns/100ps
`default_nettype none
interface hspw_gen_if;
  logic tick;
  logic [7:0] duty;
  logic slow;
  logic level;
  modport ctrl (output tick, output duty, output slow, input level);
  modport gen (input tick, input duty, input slow, output level);
endinterface
`default_nettype wire

// file: hspw_duty_gen.sv
`timescale 1ns/100ps
`default_nettype none
module hspw_duty_gen (
  input wire logic clk_sys,
  input wire logic rst_n,
  hspw_gen_if.gen gif
);
  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic [7:0] pos;

  // Slow period takes two slot ticks per duty step
  always_comb begin
    cnt_d = cnt_q;
    if (gif.tick) begin
      cnt_d = cnt_q + 9'h001;
    end
    pos = gif.slow ? cnt_q[8:1] : cnt_q[7:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 9'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign gif.level = pos < gif.duty;

  chk_duty_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    gif.duty == 8'h00 |-> !gif.level)
    else $error("generator on with zero duty");
  chk_duty_full: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (gif.duty == 8'hFF && pos != 8'hFF) |-> gif.level)
    else $error("generator off inside duty window");
endmodule
`default_nettype wire

// file: hspw_fault_filter.sv
`timescale 1ns/100ps
`default_nettype none
module hspw_fault_filter #(
  parameter int CYC = 160
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cond_i,
  output logic det_o
);
  localparam logic [hspw_pkg::FILT_W-1:0] CYC_W = CYC[hspw_pkg::FILT_W-1:0];
  logic [hspw_pkg::FILT_W-1:0] cnt_q;
  logic [hspw_pkg::FILT_W-1:0] cnt_d;

  // Any gap in the condition restarts the filter
  always_comb begin
    cnt_d = '0;
    if (cond_i) begin
      cnt_d = (cnt_q == CYC_W) ? cnt_q : cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign det_o = cond_i && (cnt_q == CYC_W);

  chk_filter_early: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(det_o) |-> $past(cnt_q) == CYC_W - 1'b1)
    else $error("fault detected before filter time");
  chk_filter_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cond_i |=> !det_o)
    else $error("fault detected right after a gap");
endmodule
`default_nettype wire

// file: hspw_top.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - In Stop and Sleep, outputs stay usable for cyclic wake sensing.
// - Open-load, overcurrent and supply shutdown stay active in Stop and Sleep.
// - In Stop and Sleep an output may stay on or follow its generator.
// - Restart and Fail-Safe force all outputs off.
// - After the failure clears, software may re-enable outputs.
// - Two independent 8-bit duty generators can drive the outputs.
// - Each generator has its own 8-bit duty setting.
// - Each generator has its own 200Hz or 400Hz select bit.
// - A generator drives an output as soon as the output selects it.
// - Each output selects timer one, timer two, generator one or two.
// - Overcurrent shuts an output down after a 16 us filter.
// - Open load on an active output is flagged after a 64 us filter.
// - Overcurrent sets a sticky flag and clears the output field to off.
// - After supply fault, resume only with recovery bit set, else clear fields.
// - Open load sets a flag, output stays on; flags clear only by software.
// - Configuration is kept in Stop and Sleep and software cannot change it there.
module hspw_top (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] dev_mode,
  input wire logic timer1_active,
  input wire logic timer2_active,
  input wire logic [3:0] oc_sense,
  input wire logic [3:0] ol_sense,
  input wire logic supply_ov,
  input wire logic supply_uv,
  output logic [3:0] high_side_output
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic rst_meta_q;
  logic rst_n;
  logic [9:0] pin_meta_q;
  logic [9:0] pin_sync_q;
  logic [3:0] oc_s;
  logic [3:0] ol_s;
  logic ov_s;
  logic uv_s;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 10'h000;
      pin_sync_q <= 10'h000;
    end else begin
      pin_meta_q <= {supply_uv, supply_ov, ol_sense, oc_sense};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign oc_s = pin_sync_q[3:0];
  assign ol_s = pin_sync_q[7:4];
  assign ov_s = pin_sync_q[8];
  assign uv_s = pin_sync_q[9];

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [1:0][7:0] duty_q;
  logic [1:0][7:0] duty_d;
  logic [1:0] period_q;
  logic [1:0] period_d;
  logic [3:0][2:0] src_q;
  logic [3:0][2:0] src_d;
  logic [3:0] oc_flag_q;
  logic [3:0] oc_flag_d;
  logic [3:0] ol_flag_q;
  logic [3:0] ol_flag_d;
  logic [2:0] sup_q;
  logic [2:0] sup_d;
  logic [7:0] rdata_d;
  logic [3:0] hs_d;
  logic forced_prev_q;
  logic fault_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Mode and supply qualification
  logic cfg_ok;
  logic forced_off;
  logic enter_forced;
  logic fault_sd;
  logic sd_rise;

  // Settings take no writes outside Normal, carried into low power as they stand
  assign cfg_ok = dev_mode == hspw_pkg::MODE_NORMAL;
  assign forced_off = (dev_mode == hspw_pkg::MODE_RESTART) ||
                      (dev_mode == hspw_pkg::MODE_FAILSAFE);
  assign enter_forced = forced_off && !forced_prev_q;
  // Supply shutdown runs in every mode, Stop and Sleep included
  assign fault_sd = (ov_s && !sup_q[hspw_pkg::SUP_OVDIS_BIT]) ||
                    (uv_s && !sup_q[hspw_pkg::SUP_UVDIS_BIT]);
  assign sd_rise = fault_sd && !fault_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Slot tick: one duty step of the 400Hz period
  logic [hspw_pkg::SLOT_W-1:0] slot_cnt_q;
  logic [hspw_pkg::SLOT_W-1:0] slot_cnt_d;
  logic slot_tick_q;
  logic slot_tick_d;
  localparam logic [hspw_pkg::SLOT_W-1:0] SLOT_LAST =
    hspw_pkg::SLOT_W'(hspw_pkg::SLOT_CYC - 1);

  always_comb begin
    slot_tick_d = slot_cnt_q == SLOT_LAST;
    slot_cnt_d = slot_tick_d ? '0 : slot_cnt_q + 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      slot_cnt_q <= '0;
      slot_tick_q <= 1'b0;
    end else begin
      slot_cnt_q <= slot_cnt_d;
      slot_tick_q <= slot_tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty generators
  logic [1:0] gen_lvl;

  for (genvar g = 0; g < 2; g++) begin : g_gen
    hspw_gen_if gif ();
    assign gif.tick = slot_tick_q;
    assign gif.duty = duty_q[g];
    assign gif.slow = period_q[g];
    assign gen_lvl[g] = gif.level;
    hspw_duty_gen u_gen (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .gif(gif.gen)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault filters, sensing only while the switch is on
  logic [3:0] oc_det;
  logic [3:0] ol_det;

  for (genvar i = 0; i < 4; i++) begin : g_flt
    hspw_fault_filter #(.CYC(hspw_pkg::OC_FILTER_CYC)) u_oc (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .cond_i(oc_s[i] && high_side_output[i]),
      .det_o(oc_det[i])
    );
    hspw_fault_filter #(.CYC(hspw_pkg::OL_FILTER_CYC)) u_ol (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .cond_i(ol_s[i] && high_side_output[i]),
      .det_o(ol_det[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and hardware updates
  always_comb begin
    duty_d = duty_q;
    period_d = period_q;
    src_d = src_q;
    sup_d = sup_q;
    oc_flag_d = oc_flag_q;
    ol_flag_d = ol_flag_q;
    if (reg_wr && cfg_ok) begin
      unique case (reg_addr)
        hspw_pkg::ADDR_DUTY1: duty_d[0] = reg_wdata;
        hspw_pkg::ADDR_DUTY2: duty_d[1] = reg_wdata;
        hspw_pkg::ADDR_PERIOD: period_d = reg_wdata[1:0];
        hspw_pkg::ADDR_SRC_A: begin
          src_d[0] = reg_wdata[2:0];
          src_d[1] = reg_wdata[5:3];
        end
        hspw_pkg::ADDR_SRC_B: begin
          src_d[2] = reg_wdata[2:0];
          src_d[3] = reg_wdata[5:3];
        end
        hspw_pkg::ADDR_SUPPLY: sup_d = reg_wdata[2:0];
        default: ;
      endcase
    end
    // Flags clear by writing ones, in any mode
    if (reg_wr && reg_addr == hspw_pkg::ADDR_OC_FLAG) begin
      oc_flag_d = oc_flag_q & ~reg_wdata[3:0];
    end
    if (reg_wr && reg_addr == hspw_pkg::ADDR_OL_FLAG) begin
      ol_flag_d = ol_flag_q & ~reg_wdata[3:0];
    end
    // Failure exit needs a fresh enable from software
    if (enter_forced) begin
      src_d = '0;
    end
    if (sd_rise && !sup_q[hspw_pkg::SUP_REC_BIT]) begin
      src_d = '0;
    end
    // Hardware events win over a same-cycle clear or write
    for (int i = 0; i < 4; i++) begin
      if (oc_det[i]) begin
        oc_flag_d[i] = 1'b1;
        src_d[i] = hspw_pkg::SRC_OFF;
      end
      if (ol_det[i]) begin
        ol_flag_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      duty_q <= {hspw_pkg::DUTY_RST, hspw_pkg::DUTY_RST};
      period_q <= hspw_pkg::PERIOD_RST;
      src_q <= '0;
      sup_q <= hspw_pkg::SUPPLY_RST;
      oc_flag_q <= 4'h0;
      ol_flag_q <= 4'h0;
      forced_prev_q <= 1'b0;
      fault_prev_q <= 1'b0;
    end else begin
      duty_q <= duty_d;
      period_q <= period_d;
      src_q <= src_d;
      sup_q <= sup_d;
      oc_flag_q <= oc_flag_d;
      ol_flag_q <= ol_flag_d;
      forced_prev_q <= forced_off;
      fault_prev_q <= fault_sd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drive
  // Stop and Sleep keep driving from the source, so timers can serve wake sensing
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      unique case (src_q[i])
        hspw_pkg::SRC_ON: hs_d[i] = 1'b1;
        hspw_pkg::SRC_TIMER1: hs_d[i] = timer1_active;
        hspw_pkg::SRC_TIMER2: hs_d[i] = timer2_active;
        hspw_pkg::SRC_GEN1: hs_d[i] = gen_lvl[0];
        hspw_pkg::SRC_GEN2: hs_d[i] = gen_lvl[1];
        default: hs_d[i] = 1'b0;
      endcase
      // Open load leaves the switch on; overcurrent cuts it at once
      if (forced_off || fault_sd || oc_det[i]) begin
        hs_d[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      high_side_output <= 4'h0;
    end else begin
      high_side_output <= hs_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        hspw_pkg::ADDR_DUTY1: rdata_d = duty_q[0];
        hspw_pkg::ADDR_DUTY2: rdata_d = duty_q[1];
        hspw_pkg::ADDR_PERIOD: rdata_d = {6'h00, period_q};
        hspw_pkg::ADDR_SRC_A: rdata_d = {2'h0, src_q[1], src_q[0]};
        hspw_pkg::ADDR_SRC_B: rdata_d = {2'h0, src_q[3], src_q[2]};
        hspw_pkg::ADDR_OC_FLAG: rdata_d = {4'h0, oc_flag_q};
        hspw_pkg::ADDR_OL_FLAG: rdata_d = {4'h0, ol_flag_q};
        hspw_pkg::ADDR_SUPPLY: rdata_d = {5'h00, sup_q};
        hspw_pkg::ADDR_STATUS: begin
          rdata_d[3:0] = high_side_output;
          rdata_d[hspw_pkg::STAT_OV_BIT] = ov_s;
          rdata_d[hspw_pkg::STAT_UV_BIT] = uv_s;
          rdata_d[hspw_pkg::STAT_FORCED_BIT] = forced_off;
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_forced_off: assert property (forced_off |=> high_side_output == 4'h0)
    else $error("output on in restart or fail-safe");
  chk_supply_off: assert property (fault_sd |=> high_side_output == 4'h0)
    else $error("output on during supply shutdown");
  chk_cfg_locked: assert property (
    (reg_wr && !cfg_ok && reg_addr == hspw_pkg::ADDR_SRC_A && !(|oc_det)
     && !enter_forced && !sd_rise) |=> $stable(src_q[0]))
    else $error("source changed outside normal mode");
  // Output 2 is the one the load model shorts and opens
  chk_oc_clears: assert property (
    oc_det[2] |=> (src_q[2] == hspw_pkg::SRC_OFF && oc_flag_q[2] && !high_side_output[2]))
    else $error("overcurrent did not shut output down");
  chk_flag_sticky: assert property (
    (ol_flag_q[2] && !(reg_wr && reg_addr == hspw_pkg::ADDR_OL_FLAG)) |=> ol_flag_q[2])
    else $error("open-load flag cleared without write");
  chk_timer_follow: assert property (
    (src_q[0] == hspw_pkg::SRC_TIMER1 && !forced_off && !fault_sd && !oc_det[0])
    |=> high_side_output[0] == $past(timer1_active))
    else $error("output not following timer one");
  chk_gen_follow: assert property (
    (src_q[1] == hspw_pkg::SRC_GEN2 && !forced_off && !fault_sd && !oc_det[1])
    |=> high_side_output[1] == $past(gen_lvl[1]))
    else $error("output not following generator two");
  chk_no_recover: assert property (
    (sd_rise && !sup_q[hspw_pkg::SUP_REC_BIT]) |=> src_q == '0)
    else $error("fields kept without recovery bit");
  chk_read_late: assert property (
    (reg_rd && reg_addr == hspw_pkg::ADDR_DUTY1 && !reg_wr) |=> reg_rdata == $past(duty_q[0]))
    else $error("duty read back wrong");
endmodule
`default_nettype wire

// file: hspw_load_model.sv
`timescale 1ns/100ps
`default_nettype none
module hspw_load_model (
  input wire logic [3:0] drive,
  input wire logic [3:0] short_en,
  input wire logic [3:0] open_en,
  output logic [3:0] oc_sense,
  output logic [3:0] ol_sense
);
  // Comparators only see load current while the switch conducts
  assign oc_sense = drive & short_en;
  assign ol_sense = drive & open_en;
endmodule
`default_nettype wire

// file: hspw_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define HSPW_CHECK(what, exp, got) \
  begin \
    num_checks++; \
    if ((exp) !== (got)) begin \
      errors++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end
module hspw_top_bench;
  typedef struct {string what; logic [7:0] exp;} hspw_note_type;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [2:0] dev_mode = hspw_pkg::MODE_NORMAL;
  logic timer1_active = 1'b0;
  logic timer2_active = 1'b0;
  logic [3:0] oc_sense;
  logic [3:0] ol_sense;
  logic supply_ov = 1'b0;
  logic supply_uv = 1'b0;
  logic [3:0] high_side_output;
  logic [3:0] short_en = 4'h0;
  logic [3:0] open_en = 4'h0;
  logic out_chk = 1'b0;
  logic rd_seen = 1'b0;
  logic out_seen = 1'b0;
  int errors = 0;
  int num_checks = 0;
  hspw_note_type notes[$];

  always #50 clk_sys = ~clk_sys;

  hspw_top dut (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .dev_mode(dev_mode),
    .timer1_active(timer1_active),
    .timer2_active(timer2_active),
    .oc_sense(oc_sense),
    .ol_sense(ol_sense),
    .supply_ov(supply_ov),
    .supply_uv(supply_uv),
    .high_side_output(high_side_output)
  );

  hspw_load_model load (
    .drive(high_side_output),
    .short_en(short_en),
    .open_en(open_en),
    .oc_sense(oc_sense),
    .ol_sense(ol_sense)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read data stands one cycle only, so it is taken at the next negedge
  always @(posedge clk_sys) begin
    rd_seen <= reg_rd;
    out_seen <= out_chk;
  end

  always @(negedge clk_sys) begin
    hspw_note_type n;
    if (rd_seen && notes.size() > 0) begin
      n = notes.pop_front();
      `HSPW_CHECK(n.what, n.exp, reg_rdata)
    end
    if (out_seen && notes.size() > 0) begin
      n = notes.pop_front();
      `HSPW_CHECK(n.what, n.exp[3:0], high_side_output)
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string w);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    notes.push_back('{w, e});
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  task automatic see(input logic [3:0] e, input string w);
    @(posedge clk_sys);
    out_chk <= 1'b1;
    notes.push_back('{w, {4'h0, e}});
    @(posedge clk_sys);
    out_chk <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic mode(input logic [2:0] m);
    @(posedge clk_sys);
    dev_mode <= m;
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge clk_sys);
    errors++;
    close_out();
  end

  initial begin
    int d1;
    int d2;
    int hi1;
    int hi2;
    d1 = $urandom(75288);
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    idle(3);
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], 8'h00, "reset value");
    end
    // Duties kept at or above the detection minimum
    d1 = 4 + ($urandom % 252);
    d2 = 4 + ($urandom % 252);
    wr(hspw_pkg::ADDR_DUTY1, d1[7:0]);
    wr(hspw_pkg::ADDR_DUTY2, d2[7:0]);
    wr(hspw_pkg::ADDR_PERIOD, 8'h02);
    rd(hspw_pkg::ADDR_DUTY1, d1[7:0], "duty gen1");
    rd(hspw_pkg::ADDR_DUTY2, d2[7:0], "duty gen2");
    rd(hspw_pkg::ADDR_PERIOD, 8'h02, "period select");
    wr(hspw_pkg::ADDR_SRC_A, {2'b00, hspw_pkg::SRC_GEN2, hspw_pkg::SRC_GEN1});
    idle(2);
    // Whole slow period holds two fast periods, so counts are phase free
    hi1 = 0;
    hi2 = 0;
    repeat (2 * hspw_pkg::DUTY_STEPS * hspw_pkg::SLOT_CYC) begin
      @(negedge clk_sys);
      hi1 += (high_side_output[0] === 1'b1) ? 1 : 0;
      hi2 += (high_side_output[1] === 1'b1) ? 1 : 0;
    end
    `HSPW_CHECK("gen1 on time", 2 * d1 * hspw_pkg::SLOT_CYC, hi1)
    `HSPW_CHECK("gen2 on time", 2 * d2 * hspw_pkg::SLOT_CYC, hi2)
    wr(hspw_pkg::ADDR_SRC_A, 8'h1A);
    wr(hspw_pkg::ADDR_SRC_B, {5'h00, hspw_pkg::SRC_ON});
    for (int t = 0; t < 4; t++) begin
      @(posedge clk_sys);
      timer1_active <= t[0];
      timer2_active <= t[1];
      see({2'b01, t[1], t[0]}, "timer outputs");
    end
    rd(hspw_pkg::ADDR_STATUS, 8'h07, "status outputs");
    // Everything is configured before low power is entered
    mode(hspw_pkg::MODE_STOP);
    see(4'h7, "stop keeps outputs");
    wr(hspw_pkg::ADDR_SRC_A, 8'h00);
    rd(hspw_pkg::ADDR_SRC_A, 8'h1A, "frozen config");
    @(posedge clk_sys);
    timer1_active <= 1'b0;
    see(4'h6, "stop timer follow");
    for (int m = 3; m < 5; m++) begin
      mode(m[2:0]);
      see(4'h0, "forced off");
      rd(hspw_pkg::ADDR_STATUS, 8'h40, "forced status");
      mode(hspw_pkg::MODE_NORMAL);
      see(4'h0, "stays off");
      wr(hspw_pkg::ADDR_SRC_A, 8'h1A);
      wr(hspw_pkg::ADDR_SRC_B, 8'h01);
      see(4'h6, "re-enable");
    end
    // Short on output 2 while in low power
    mode(hspw_pkg::MODE_STOP);
    @(posedge clk_sys);
    short_en <= 4'h4;
    idle(150);
    see(4'h6, "before oc filter");
    idle(20);
    see(4'h2, "oc shutdown");
    rd(hspw_pkg::ADDR_OC_FLAG, 8'h04, "oc flag");
    rd(hspw_pkg::ADDR_SRC_B, 8'h00, "oc field cleared");
    mode(hspw_pkg::MODE_NORMAL);
    short_en <= 4'h0;
    idle(5);
    rd(hspw_pkg::ADDR_OC_FLAG, 8'h04, "oc flag sticky");
    wr(hspw_pkg::ADDR_OC_FLAG, 8'h04);
    rd(hspw_pkg::ADDR_OC_FLAG, 8'h00, "oc flag cleared");
    wr(hspw_pkg::ADDR_SRC_B, 8'h01);
    @(posedge clk_sys);
    open_en <= 4'h4;
    idle(600);
    rd(hspw_pkg::ADDR_OL_FLAG, 8'h00, "before ol filter");
    idle(60);
    rd(hspw_pkg::ADDR_OL_FLAG, 8'h04, "ol flag");
    see(4'h6, "ol output on");
    open_en <= 4'h0;
    idle(5);
    rd(hspw_pkg::ADDR_OL_FLAG, 8'h04, "ol flag sticky");
    wr(hspw_pkg::ADDR_OL_FLAG, 8'h04);
    rd(hspw_pkg::ADDR_OL_FLAG, 8'h00, "ol flag cleared");
    // Supply fault without recovery, then with it
    supply_ov <= 1'b1;
    idle(5);
    see(4'h0, "ov off");
    rd(hspw_pkg::ADDR_STATUS, 8'h10, "ov status");
    supply_ov <= 1'b0;
    idle(5);
    see(4'h0, "no recovery");
    rd(hspw_pkg::ADDR_SRC_A, 8'h00, "fields cleared");
    wr(hspw_pkg::ADDR_SUPPLY, 8'h01);
    wr(hspw_pkg::ADDR_SRC_A, 8'h1A);
    wr(hspw_pkg::ADDR_SRC_B, 8'h01);
    supply_uv <= 1'b1;
    idle(5);
    see(4'h0, "uv off");
    supply_uv <= 1'b0;
    idle(5);
    see(4'h6, "recovered");
    idle(3);
    close_out();
  end
endmodule
`undef HSPW_CHECK
`default_nettype wire
